// ### design/sfc_defs.vh
// Register map, field positions, reset values and sizes of the sample queue
`ifndef SFC_DEFS_VH
`define SFC_DEFS_VH

// Register offsets
`define SFC_OFS_STATUS1 8'h00
`define SFC_OFS_WR_INDEX 8'h08
`define SFC_OFS_RD_INDEX 8'h09
`define SFC_OFS_COUNT_HI 8'h0A
`define SFC_OFS_COUNT_LO 8'h0B
`define SFC_OFS_READ_PORT 8'h0C
`define SFC_OFS_THRESHOLD 8'h0D
`define SFC_OFS_CONTROL 8'h0E

// Control register fields
`define SFC_BIT_MARK 5
`define SFC_BIT_FLUSH 4
`define SFC_BIT_STAT_CLR 3
`define SFC_BIT_AF_TYPE 2
`define SFC_BIT_ROLLOVER 1

// Status 1 fields
`define SFC_BIT_A_FULL 7
`define SFC_BIT_DATA_RDY 5

// Reset values
`define SFC_RST_THRESHOLD 8'h7F
`define SFC_RST_STAT_CLR 1'b1
`define SFC_RST_AF_TYPE 1'b0
`define SFC_RST_ROLLOVER 1'b1
`define SFC_RST_READ_PORT 8'hFF
`define SFC_RST_INDEX 8'h00
`define SFC_RST_COUNT 9'h000
`define SFC_RST_LOST 7'h00

// Sizes and limits
`define SFC_QUEUE_ENTRIES 9'h100
`define SFC_LOST_MAX 7'h7F
`define SFC_LAST_BYTE 2'h2
`define SFC_EMPTY_READ 8'hFF
`define SFC_MARKER_WORD 24'hFF_FFFE
`define SFC_STAGE_DEPTH 8

`endif

// ### design/sfc_store.v
// Sample storage: flip-flop array with one write port and one indexed read
`timescale 1ns/10ps
`default_nettype none

module sfc_store #(
	parameter W = 24,
	parameter AW = 8
) (
	input wire core_clk,
	input wire wr_en,
	input wire [AW-1:0] wr_index,
	input wire [W-1:0] wr_data,
	input wire [AW-1:0] rd_index,
	output wire [W-1:0] rd_data
);

	reg [W-1:0] mem_q [0:(1<<AW)-1];

	always @(posedge core_clk) begin
		if (wr_en) begin
			mem_q[wr_index] <= wr_data;
		end
	end

	assign rd_data = mem_q[rd_index];

endmodule
`default_nettype wire

// ### design/sfc_stage_fifo.v
// Small staging buffer between the converters and the sample queue
`timescale 1ns/10ps
`default_nettype none

module sfc_stage_fifo #(
	parameter W = 24,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire core_clk,
	input wire rst,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);

	reg [W-1:0] buf_q [0:DEPTH-1];
	reg [AW-1:0] head_q;
	reg [AW-1:0] tail_q;
	reg [AW:0] used_q;
	wire do_in;
	wire do_out;

	assign in_ready = (used_q != DEPTH[AW:0]);
	assign out_valid = (used_q != {(AW+1){1'b0}});
	assign out_data = buf_q[head_q];
	assign do_in = in_valid & in_ready;
	assign do_out = out_valid & out_ready;

	always @(posedge core_clk) begin
		if (do_in) begin
			buf_q[tail_q] <= in_data;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			head_q <= {AW{1'b0}};
			tail_q <= {AW{1'b0}};
			used_q <= {(AW+1){1'b0}};
		end else begin
			if (do_in) begin
				tail_q <= (tail_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : tail_q + 1'b1;
			end
			if (do_out) begin
				head_q <= (head_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : head_q + 1'b1;
			end
			if (do_in & ~do_out) begin
				used_q <= used_q + 1'b1;
			end else if (do_out & ~do_in) begin
				used_q <= used_q - 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// ### design/sfc_top.v
// Sample queue control: circular store, counters, flags and register port
`timescale 1ns/10ps
`default_nettype none
`include "sfc_defs.vh"

// Overview of operation
// [RL1] Nine-bit fill count, up on push, down on read
// [RL2] Lost-sample tally counts samples discarded when full
// [RL3] Completed sample read clears the lost tally
// [RL4] Lost tally saturates at its maximum
// [RL5] Host reads lost tally before draining
// [RL6] Data port burst reads, address stays fixed
// [RL7] Three bytes read advance read index once
// [RL8] Almost-full at 256 minus threshold, resets 0x7F
// [RL9] Almost-full with enable drives interrupt pin
// [RL10] Status one read clears almost-full and interrupt
// [RL11] Marker bit pushes marker entry, self-clears
// [RL12] Flush bit zeroes queue state, self-clears
// [RL13] Clear type adds data-read clearing to status-read clearing
// [RL14] Type zero: reassert on every new sample
// [RL15] Type one: reassert only after read, new condition
// [RL16] Rollover on: overwrite oldest, both indices advance
// [RL17] Rollover off: drop new samples, only lost tally changes
// [RL18] Write index points next slot, wraps to zero
// [RL19] Read index rewritten only with PLL enabled
// [RL20] 256 entries of three bytes, full at 256
module sfc_top #(
	parameter SAMPLE_W = 24,
	parameter STAGE_DEPTH = `SFC_STAGE_DEPTH,
	parameter [23:0] MARKER_WORD = `SFC_MARKER_WORD
) (
	input wire core_clk,
	input wire rst,
	input wire sample_valid,
	input wire [SAMPLE_W-1:0] sample_data,
	output wire sample_ready,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	output wire [7:0] reg_rdata,
	input wire pll_enabled,
	input wire a_full_int_en,
	output wire a_full_flag,
	output wire data_rdy_flag,
	output wire a_full_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function [7:0] pick_byte;
		input [23:0] word;
		input [1:0] idx;
		case (idx)
			2'h0: pick_byte = word[23:16];
			2'h1: pick_byte = word[15:8];
			default: pick_byte = word[7:0];
		endcase
	endfunction

	function hit;
		input [7:0] addr;
		input [7:0] ofs;
		hit = (addr == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State

	reg [7:0] write_index_q;
	reg [7:0] write_index_d;
	reg [7:0] read_index_q;
	reg [7:0] read_index_d;
	reg [8:0] count_q;
	reg [8:0] count_d;
	reg [6:0] lost_sample_tally_q;
	reg [6:0] lost_sample_tally_d;
	reg [1:0] byte_q;
	reg [1:0] byte_d;
	reg [7:0] threshold_q;
	reg data_read_clears_flags_q;
	reg af_type_q;
	reg rollover_on_full_q;
	reg a_full_q;
	reg a_full_d;
	reg data_rdy_q;
	reg data_rdy_d;
	reg af_armed_q;
	reg af_armed_d;
	reg [7:0] rdata_q;
	reg [7:0] rdata_d;

	////////////////////////////////////////////////////////////////////////////////
	// Decode of host accesses

	wire ctrl_wr;
	wire mark_go;
	wire flush_go;
	wire rd_index_wr;
	wire data_rd;
	wire status_rd;
	wire empty;
	wire full;
	wire pop;
	wire room;

	assign ctrl_wr = reg_wr & hit(reg_addr, `SFC_OFS_CONTROL);
	assign mark_go = ctrl_wr & reg_wdata[`SFC_BIT_MARK];  // see [RL11]
	assign flush_go = ctrl_wr & reg_wdata[`SFC_BIT_FLUSH];  // see [RL12]
	// Ignored unless the PLL runs
	assign rd_index_wr = reg_wr & hit(reg_addr, `SFC_OFS_RD_INDEX) & pll_enabled;  // see [RL19]
	// Address is never advanced here; every data read of a non-empty queue pulls the next byte
	assign data_rd = reg_rd & hit(reg_addr, `SFC_OFS_READ_PORT);  // see [RL6]
	assign status_rd = reg_rd & hit(reg_addr, `SFC_OFS_STATUS1);

	assign empty = (count_q == `SFC_RST_COUNT);
	assign full = (count_q == `SFC_QUEUE_ENTRIES);  // see [RL20]
	assign pop = data_rd & ~empty & (byte_q == `SFC_LAST_BYTE);  // see [RL7]
	// A pop in the same cycle frees a slot for the push
	assign room = ~full | pop;

	////////////////////////////////////////////////////////////////////////////////
	// Staging buffer and push selection

	wire stage_valid;
	wire stage_ready;
	wire [SAMPLE_W-1:0] stage_data;
	wire push;
	wire [23:0] push_data;
	wire store_it;
	wire overwrite;
	wire lost_ev;
	wire [23:0] head_word;

	// Buffer drain stalls while the host manipulates the queue
	assign stage_ready = ~mark_go & ~flush_go & ~rd_index_wr;

	sfc_stage_fifo #(
		.W(SAMPLE_W),
		.DEPTH(STAGE_DEPTH),
		.AW(3)
	) u_stage (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.in_data(sample_data),
		.out_valid(stage_valid),
		.out_ready(stage_ready),
		.out_data(stage_data)
	);

	assign push = (stage_valid & stage_ready) | (mark_go & ~flush_go);
	assign push_data = mark_go ? MARKER_WORD : stage_data[23:0];  // see [RL11]
	assign store_it = push & (room | rollover_on_full_q);  // see [RL16] [RL17]
	assign overwrite = push & ~room & rollover_on_full_q;  // see [RL16]
	assign lost_ev = push & ~room;  // see [RL2]

	sfc_store #(
		.W(24),
		.AW(8)
	) u_store (
		.core_clk(core_clk),
		.wr_en(store_it),
		.wr_index(write_index_q),
		.wr_data(push_data),
		.rd_index(read_index_q),
		.rd_data(head_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Indices, count, byte position and lost tally

	always @* begin
		write_index_d = write_index_q;
		if (flush_go) begin
			write_index_d = `SFC_RST_INDEX;  // see [RL12]
		end else if (store_it) begin
			write_index_d = write_index_q + 8'h01;  // see [RL18]
		end
	end

	always @* begin
		read_index_d = read_index_q;
		if (flush_go) begin
			read_index_d = `SFC_RST_INDEX;  // see [RL12]
		end else if (rd_index_wr) begin
			read_index_d = reg_wdata;  // see [RL19]
		end else if (pop | overwrite) begin
			read_index_d = read_index_q + 8'h01;  // see [RL7] [RL16]
		end
	end

	always @* begin
		count_d = count_q;
		if (flush_go) begin
			count_d = `SFC_RST_COUNT;  // see [RL12]
		end else if (rd_index_wr) begin
			count_d = {1'b0, write_index_q - reg_wdata};
		end else if ((store_it & ~overwrite) & ~pop) begin
			count_d = count_q + 9'h001;  // see [RL1]
		end else if (pop & ~(store_it & ~overwrite)) begin
			count_d = count_q - 9'h001;  // see [RL1]
		end
	end

	always @* begin
		byte_d = byte_q;
		if (flush_go | rd_index_wr) begin
			byte_d = 2'h0;
		end else if (data_rd & ~empty) begin
			byte_d = (byte_q == `SFC_LAST_BYTE) ? 2'h0 : byte_q + 2'h1;  // see [RL7]
		end
	end

	always @* begin
		lost_sample_tally_d = lost_sample_tally_q;
		if (flush_go) begin
			lost_sample_tally_d = `SFC_RST_LOST;  // see [RL12]
		end else if (pop) begin
			lost_sample_tally_d = `SFC_RST_LOST;  // see [RL3]
		end else if (lost_ev & (lost_sample_tally_q != `SFC_LOST_MAX)) begin
			lost_sample_tally_d = lost_sample_tally_q + 7'h01;  // see [RL2] [RL4]
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			write_index_q <= `SFC_RST_INDEX;
			read_index_q <= `SFC_RST_INDEX;
			count_q <= `SFC_RST_COUNT;
			byte_q <= 2'h0;
			lost_sample_tally_q <= `SFC_RST_LOST;
		end else begin
			write_index_q <= write_index_d;
			read_index_q <= read_index_d;
			count_q <= count_d;
			byte_q <= byte_d;
			lost_sample_tally_q <= lost_sample_tally_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	always @(posedge core_clk) begin
		if (rst) begin
			threshold_q <= `SFC_RST_THRESHOLD;  // see [RL8]
		end else if (reg_wr & hit(reg_addr, `SFC_OFS_THRESHOLD)) begin
			threshold_q <= reg_wdata;
		end
	end

	// Marker and flush bits are strobes, never stored
	always @(posedge core_clk) begin
		if (rst) begin
			data_read_clears_flags_q <= `SFC_RST_STAT_CLR;
			af_type_q <= `SFC_RST_AF_TYPE;
			rollover_on_full_q <= `SFC_RST_ROLLOVER;
		end else if (ctrl_wr) begin
			data_read_clears_flags_q <= reg_wdata[`SFC_BIT_STAT_CLR];
			af_type_q <= reg_wdata[`SFC_BIT_AF_TYPE];
			rollover_on_full_q <= reg_wdata[`SFC_BIT_ROLLOVER];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Almost-full and data-ready flags

	wire [8:0] af_level;
	wire af_cond;
	wire af_set;
	wire flag_clr;

	assign af_level = `SFC_QUEUE_ENTRIES - {1'b0, threshold_q};  // see [RL8]
	assign af_cond = (count_d >= af_level);  // see [RL8]
	// Type zero sets on every sample, type one only while armed
	assign af_set = store_it & af_cond & (~af_type_q | af_armed_q);  // see [RL14] [RL15]
	assign flag_clr = status_rd | (data_rd & data_read_clears_flags_q);  // see [RL10] [RL13]

	always @* begin
		a_full_d = a_full_q;
		if (af_set) begin
			a_full_d = 1'b1;
		end else if (flag_clr) begin
			a_full_d = 1'b0;  // see [RL10]
		end
	end

	always @* begin
		data_rdy_d = data_rdy_q;
		if (store_it) begin
			data_rdy_d = 1'b1;
		end else if (flag_clr) begin
			data_rdy_d = 1'b0;  // see [RL13]
		end
	end

	// Rearmed by a completed sample read
	always @* begin
		af_armed_d = af_armed_q;
		if (pop) begin
			af_armed_d = 1'b1;  // see [RL15]
		end else if (af_set) begin
			af_armed_d = 1'b0;  // see [RL15]
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			a_full_q <= 1'b0;
			data_rdy_q <= 1'b0;
			af_armed_q <= 1'b1;
		end else begin
			a_full_q <= a_full_d;
			data_rdy_q <= data_rdy_d;
			af_armed_q <= af_armed_d;
		end
	end

	assign a_full_flag = a_full_q;
	assign data_rdy_flag = data_rdy_q;
	assign a_full_irq = a_full_q & a_full_int_en;  // see [RL9]

	////////////////////////////////////////////////////////////////////////////////
	// Read data

	always @* begin
		rdata_d = rdata_q;
		if (reg_rd) begin
			case (reg_addr)
				`SFC_OFS_STATUS1: begin
					rdata_d = 8'h00;
					rdata_d[`SFC_BIT_A_FULL] = a_full_q;
					rdata_d[`SFC_BIT_DATA_RDY] = data_rdy_q;
				end
				`SFC_OFS_WR_INDEX: rdata_d = write_index_q;
				`SFC_OFS_RD_INDEX: rdata_d = read_index_q;
				`SFC_OFS_COUNT_HI: rdata_d = {count_q[8], lost_sample_tally_q};  // see [RL1] [RL2]
				`SFC_OFS_COUNT_LO: rdata_d = count_q[7:0];  // see [RL1]
				`SFC_OFS_READ_PORT: rdata_d = empty ? `SFC_EMPTY_READ : pick_byte(head_word, byte_q);  // see [RL6] [RL7]
				`SFC_OFS_THRESHOLD: rdata_d = threshold_q;
				`SFC_OFS_CONTROL: begin
					rdata_d = 8'h00;
					rdata_d[`SFC_BIT_STAT_CLR] = data_read_clears_flags_q;
					rdata_d[`SFC_BIT_AF_TYPE] = af_type_q;
					rdata_d[`SFC_BIT_ROLLOVER] = rollover_on_full_q;
				end
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			rdata_q <= `SFC_RST_READ_PORT;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

// ### tb/sfc_src.sv
// Converter-side sample source for the sample queue
`timescale 1ns/10ps
`default_nettype none

module sfc_src (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [15:0] quota,
	input wire logic sample_ready,
	output logic sample_valid,
	output logic [23:0] sample_data,
	output logic [15:0] sent
);
	logic [15:0] sent_q;

	// Word and valid held until accepted
	assign sent = sent_q;
	assign sample_valid = sent_q < quota;
	assign sample_data = {8'hC3, sent_q};

	always @(posedge core_clk) begin
		if (rst) begin
			sent_q <= 16'h0000;
		end else if (sample_valid && sample_ready) begin
			sent_q <= sent_q + 16'h0001;
		end
	end
endmodule

`default_nettype wire

// ### tb/sfc_top_sva.sv
// Port checker for the sample queue control block
`timescale 1ns/10ps
`default_nettype none

module sfc_top_sva #(
	parameter SAMPLE_W = 24
) (
	input wire core_clk,
	input wire rst,
	input wire sample_valid,
	input wire [SAMPLE_W-1:0] sample_data,
	input wire sample_ready,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire pll_enabled,
	input wire a_full_int_en,
	input wire a_full_flag,
	input wire data_rdy_flag,
	input wire a_full_irq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_irq;
		a_full_irq == (a_full_flag && a_full_int_en);
	endproperty
	a_irq: assert property (p_irq) else $error("irq differs from flag and enable");
	property p_stat;
		reg_rd && reg_addr == 8'h00 |=> reg_rdata == {$past(a_full_flag), 1'b0, $past(data_rdy_flag), 5'h00};
	endproperty
	a_stat: assert property (p_stat) else $error("status byte wrong");
	property p_rst;
		disable iff (1'b0) rst |=> reg_rdata == 8'hFF && !a_full_flag && !a_full_irq && !data_rdy_flag;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_unmap;
		reg_rd && reg_addr == 8'h05 |=> reg_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_hold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved without a read");
	property p_ready;
		$fell(rst) |-> sample_ready;
	endproperty
	a_ready: assert property (p_ready) else $error("not ready after reset");
	property p_thr;
		reg_wr && reg_addr == 8'h0D ##2 reg_rd && reg_addr == 8'h0D |=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	a_thr: assert property (p_thr) else $error("threshold readback wrong");
	property p_ctl;
		reg_rd && reg_addr == 8'h0E |=> reg_rdata[5:4] == 2'h0;
	endproperty
	a_ctl: assert property (p_ctl) else $error("control strobe bits not clear");
endmodule

bind sfc_top sfc_top_sva #(.SAMPLE_W(SAMPLE_W)) u_sfc_top_sva (.core_clk(core_clk), .rst(rst),
	.sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(sample_ready), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_enabled(pll_enabled),
	.a_full_int_en(a_full_int_en), .a_full_flag(a_full_flag), .data_rdy_flag(data_rdy_flag),
	.a_full_irq(a_full_irq));

`default_nettype wire

// ### tb/tb_sfc_top.sv
// Register-level testbench for the sample queue control block
`timescale 1ns/10ps
`default_nettype none

module tb_sfc_top;
	logic core_clk;
	logic rst;
	logic reg_wr;
	logic reg_rd;
	logic pll_enabled;
	logic a_full_int_en;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [15:0] quota;
	wire [7:0] reg_rdata;
	wire [23:0] sample_data;
	wire [15:0] sent;
	wire sample_valid;
	wire sample_ready;
	wire a_full_flag;
	wire data_rdy_flag;
	wire a_full_irq;
	int fails = 0;
	int samples_checked = 0;

	sfc_top u_sfc_top (.core_clk(core_clk), .rst(rst), .sample_valid(sample_valid), .sample_data(sample_data),
		.sample_ready(sample_ready), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pll_enabled(pll_enabled), .a_full_int_en(a_full_int_en),
		.a_full_flag(a_full_flag), .data_rdy_flag(data_rdy_flag), .a_full_irq(a_full_irq));
	sfc_src u_sfc_src (.core_clk(core_clk), .rst(rst), .quota(quota), .sample_ready(sample_ready),
		.sample_valid(sample_valid), .sample_data(sample_data), .sent(sent));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	// Burst of one sample, address held on the data port
	task automatic rd3(input logic [23:0] w);
		rd(8'h0C, w[23:16]);
		rd(8'h0C, w[15:8]);
		rd(8'h0C, w[7:0]);
	endtask

	task automatic push(input logic [15:0] n);
		int i;
		@(posedge core_clk);
		quota <= quota + n;
		@(posedge core_clk);
		for (i = 0; i < 3000 && sent !== quota; i++) @(posedge core_clk);
		if (sent !== quota) begin
			fails++;
			$display("[ERR] %0t sent %h quota %h", $time, sent, quota);
		end
		repeat (4) @(posedge core_clk);
		#1;
	endtask

	task automatic af(input logic [7:0] exp);
		chk({7'h00, a_full_flag}, exp);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		#(8 * 40000);
		fails++;
		test_done();
	end

	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		quota = 16'h0000;
		pll_enabled = 1'b0;
		a_full_int_en = 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd(8'h0A, 8'h00);
		rd(8'h0C, 8'hFF);
		rd(8'h0D, 8'h7F);
		rd(8'h0E, 8'h0A);
		rd(8'h05, 8'h00);
		wr(8'h0B, 8'h55);
		rd(8'h0B, 8'h00);
		push(16'h0003);
		rd(8'h0B, 8'h03);
		chk({7'h00, data_rdy_flag}, 8'h01);
		rd(8'h00, 8'h20);
		chk({7'h00, data_rdy_flag}, 8'h00);
		rd3(24'hC3_0000);
		rd(8'h0B, 8'h02);
		wr(8'h0D, 8'hFE);
		rd(8'h0D, 8'hFE);
		push(16'h0001);
		chk({7'h00, a_full_irq}, 8'h01);
		rd(8'h0C, 8'hC3);
		af(8'h00);
		rd(8'h0C, 8'h00);
		rd(8'h0C, 8'h01);
		push(16'h0001);
		rd(8'h00, 8'hA0);
		af(8'h00);
		push(16'h0001);
		af(8'h01);
		wr(8'h0E, 8'h06);
		rd(8'h00, 8'hA0);
		push(16'h0001);
		af(8'h00);
		rd3(24'hC3_0002);
		push(16'h0001);
		af(8'h01);
		@(posedge core_clk);
		a_full_int_en <= 1'b0;
		@(posedge core_clk);
		#1 chk({7'h00, a_full_irq}, 8'h00);
		@(posedge core_clk);
		a_full_int_en <= 1'b1;
		rd3(24'hC3_0003);
		af(8'h01);
		wr(8'h0E, 8'h12);
		rd(8'h0B, 8'h00);
		rd(8'h08, 8'h00);
		rd(8'h0E, 8'h02);
		wr(8'h0E, 8'h22);
		rd(8'h0B, 8'h01);
		rd3(24'hFF_FFFE);
		push(16'h0102);
		rd(8'h0A, 8'h82);
		rd(8'h0B, 8'h00);
		rd(8'h08, 8'h03);
		rd3(24'hC3_000A);
		rd(8'h0A, 8'h00);
		rd(8'h0B, 8'hFF);
		wr(8'h0E, 8'h10);
		push(16'h0182);
		rd(8'h0A, 8'hFF);
		rd(8'h08, 8'h00);
		rd3(24'hC3_010A);
		rd(8'h0A, 8'h00);
		@(posedge core_clk);
		pll_enabled <= 1'b1;
		wr(8'h09, 8'h05);
		rd(8'h09, 8'h05);
		rd(8'h0B, 8'hFB);
		rd3(24'hC3_010F);
		rd(8'h09, 8'h06);
		test_done();
	end
endmodule

`default_nettype wire
